// File: dv/isgod_decode_assertions.sv
`timescale 1ns/1ps
module isgod_decode_chk(input wire mclk_i, reset_n_i, issue_valid_i, op_valid_o, mem_access_o,
	input wire illegal_o, mask_error_o, input wire [7:0] opcode_i, op_attr_o,
	input wire [3:0] channel_select_mask_i, channel_select_mask_o,
	input wire [1:0] op_kind_o, input wire [2:0] extra_operands_o);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	wire is_gth = issue_valid_i && opcode_i inside {[8'h2F:8'h37]};
	wire is_bad = opcode_i < 8'h2C || opcode_i > 8'h56 ||
		opcode_i inside {[8'h3D:8'h3F], [8'h4C:8'h53]};
	property p_lodq;
		issue_valid_i && opcode_i == 8'h38 |=> op_kind_o == 2'h2 && !mem_access_o;
	endproperty
	a_lodq: assert property (p_lodq) else $error("lod query");
	property p_bad;
		issue_valid_i && is_bad |=> illegal_o && !op_valid_o && !mem_access_o;
	endproperty
	a_bad: assert property (p_bad) else $error("illegal op");
	property p_ok; issue_valid_i && !is_bad |=> op_valid_o && !illegal_o; endproperty
	a_ok: assert property (p_ok) else $error("legal op");
	property p_gth; is_gth |=> op_kind_o == 2'h1 && mem_access_o; endproperty
	a_gth: assert property (p_gth) else $error("gather kind");
	property p_lz;
		issue_valid_i && opcode_i inside {8'h2E, 8'h32, 8'h34, 8'h36, 8'h37} |=> op_attr_o[3];
	endproperty
	a_lz: assert property (p_lz) else $error("level zero");
	property p_msk; is_gth && $countones(channel_select_mask_i) != 1 |=> mask_error_o; endproperty
	a_msk: assert property (p_msk) else $error("mask");
	property p_g16;
		issue_valid_i && opcode_i inside {[8'h39:8'h3C], [8'h54:8'h56]} |=> op_attr_o[7];
	endproperty
	a_g16: assert property (p_g16) else $error("half deriv");
	property p_cb;
		issue_valid_i && opcode_i == 8'h45 |=> extra_operands_o == 3'h3 && op_attr_o == 8'h25;
	endproperty
	a_cb: assert property (p_cb) else $error("cmp bias clamp");
endmodule
bind isgod_decode isgod_decode_chk u_chk(.*);

// File: dv/isgod_decode_tb.sv
`timescale 1ns/1ps
module isgod_decode_tb;
	reg mclk_i = 0, reset_n_i = 0;
	wire v, ov, mem, ill, merr; wire [7:0] op, attr; wire [3:0] m, mo; wire [1:0] kind; wire [2:0] ext;
	integer n_errors = 0, total_checks = 0, i;
	// opcode, kind, attributes, extra operand count: every legal opcode once
	reg [19:0] rows [0:31] = '{
		{8'h2C,2'h0,8'h13,2'h1}, {8'h2D,2'h0,8'h15,2'h2}, {8'h2E,2'h0,8'h19,2'h1},
		{8'h2F,2'h1,8'h00,2'h0}, {8'h30,2'h1,8'h02,2'h0}, {8'h31,2'h1,8'h04,2'h1},
		{8'h32,2'h1,8'h08,2'h0}, {8'h33,2'h1,8'h01,2'h1}, {8'h34,2'h1,8'h09,2'h1},
		{8'h35,2'h1,8'h10,2'h0}, {8'h36,2'h1,8'h18,2'h0}, {8'h37,2'h1,8'h19,2'h1},
		{8'h38,2'h2,8'h00,2'h0}, {8'h39,2'h0,8'hC0,2'h0}, {8'h3A,2'h0,8'hC1,2'h1},
		{8'h3B,2'h0,8'hD0,2'h0}, {8'h3C,2'h0,8'hD1,2'h1}, {8'h40,2'h0,8'h20,2'h1},
		{8'h41,2'h0,8'h60,2'h1}, {8'h42,2'h0,8'h24,2'h2}, {8'h43,2'h0,8'h21,2'h2},
		{8'h44,2'h0,8'h61,2'h2}, {8'h45,2'h0,8'h25,2'h3}, {8'h46,2'h0,8'h30,2'h1},
		{8'h47,2'h0,8'h70,2'h1}, {8'h48,2'h0,8'h34,2'h2}, {8'h49,2'h0,8'h31,2'h2},
		{8'h4A,2'h0,8'h71,2'h2}, {8'h4B,2'h0,8'h35,2'h3}, {8'h54,2'h0,8'hE1,2'h2},
		{8'h55,2'h0,8'hF0,2'h1}, {8'h56,2'h0,8'hF1,2'h2}};
	reg [7:0] bad [0:3] = '{8'h2B, 8'h3D, 8'h50, 8'h57};
	isgod_issue_model u_iss(.mclk_i(mclk_i), .v_o(v), .op_o(op), .m_o(m));
	isgod_decode u_dut(.mclk_i(mclk_i), .reset_n_i(reset_n_i), .issue_valid_i(v), .opcode_i(op),
		.channel_select_mask_i(m), .op_valid_o(ov), .op_kind_o(kind), .op_attr_o(attr),
		.mem_access_o(mem), .channel_select_mask_o(mo), .extra_operands_o(ext), .illegal_o(ill),
		.mask_error_o(merr));
	task chk(input [7:0] g, e); total_checks++; if (g !== e) begin n_errors++;
		$display("Error at %0t: got %h exp %h", $time, g, e); end endtask
	task step(input vv, input [7:0] o, input [3:0] k); u_iss.issue(vv, o, k); @(posedge mclk_i); #1; endtask
	task results; $display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish; endtask
	initial forever #10 mclk_i = ~mclk_i;
	initial begin #100000; n_errors++; results; end
	initial begin
		repeat (16) @(posedge mclk_i);
		chk(kind, 8'h03); chk(ov, 0); chk(ill, 0);
		$display("reset done");
		@(negedge mclk_i) reset_n_i = 1;
		// back to back issues, one per cycle
		for (i = 0; i < 32; i++) begin
			step(1, rows[i][19:12], 4'h4);
			chk(ov, 1);
			chk(ill, 0);
			chk(kind, rows[i][11:10]);
			chk(attr, rows[i][9:2]);
			chk(ext, rows[i][1:0]);
			chk(mem, rows[i][11:10] != 2'h2);
			chk(mo, 4'h4);
			chk(merr, 0);
		end
		$display("table done");
		for (i = 0; i < 4; i++) begin step(1, bad[i], 4'h1); chk(ill, 1); chk(ov, 0); end
		step(1, 8'h2F, 4'h3); chk(merr, 1); chk(kind, 8'h01);
		step(0, 8'h2F, 4'h1); chk(ov, 0); chk(mem, 0);
		$display("edge cases done");
		// reset in mid-run clears valid, attributes and mem access and sets kind to none at once
		step(1, 8'h45, 4'h1);
		chk(ext, 8'h03);
		@(negedge mclk_i) reset_n_i = 0;
		#1;
		chk(ov, 0);
		chk(kind, 8'h03);
		chk(attr, 8'h00);
		chk(mem, 0);
		@(negedge mclk_i) reset_n_i = 1;
		step(1, 8'h36, 4'h8);
		chk(ov, 1);
		chk(attr, 8'h18);
		$display("mid-run reset done");
		results;
	end
endmodule

// File: dv/isgod_issue_model.sv
`timescale 1ns/1ps
module isgod_issue_model(input wire mclk_i, output reg v_o = 0, output reg [7:0] op_o = 0,
	output reg [3:0] m_o = 0);
	// released opcode lines toggle so nothing stale decodes by chance
	task issue(input v, input [7:0] op, input [3:0] m); @(negedge mclk_i); v_o = v;
		op_o = v ? op : ~op_o; m_o = m; endtask
endmodule

// File: hw/isgod_decode.v
`timescale 1ns/1ps
`include "isgod_defines.vh"
module isgod_decode (
	// clock and reset
	input wire mclk_i,
	input wire reset_n_i,
	// from issue logic
	input wire issue_valid_i,
	input wire [7:0] opcode_i,
	input wire [3:0] channel_select_mask_i,
	// to texture pipe
	output reg op_valid_o,
	output reg [1:0] op_kind_o,
	output reg [7:0] op_attr_o,
	output reg mem_access_o,
	output reg [3:0] channel_select_mask_o,
	output reg [2:0] extra_operands_o,
	output reg illegal_o,
	output reg mask_error_o
);
	// attr order: g16 der clamp ofs lz bias lod cmp
	// one function per output field, so each rule reads as a plain list
	// of opcodes; a wrong entry shows up in one place only

	// operation kind; holes between the legal runs fall to none
	function [1:0] op_kind;
		input [7:0] op;
		begin
			case (op)
				`ISGOD_OP_FILT_CMP_LOD_OFS,
				`ISGOD_OP_FILT_CMP_BIAS_OFS,
				`ISGOD_OP_FILT_CMP_LVL0_OFS,
				`ISGOD_OP_FILT_HDER,
				`ISGOD_OP_FILT_CMP_HDER,
				`ISGOD_OP_FILT_OFS_HDER,
				`ISGOD_OP_FILT_CMP_OFS_HDER,
				`ISGOD_OP_CLP,
				`ISGOD_OP_CLP_DER,
				`ISGOD_OP_CLP_BIAS,
				`ISGOD_OP_CLP_CMP,
				`ISGOD_OP_CLP_CMP_DER,
				`ISGOD_OP_CLP_CMP_BIAS,
				`ISGOD_OP_CLP_OFS,
				`ISGOD_OP_CLP_DER_OFS,
				`ISGOD_OP_CLP_BIAS_OFS,
				`ISGOD_OP_CLP_CMP_OFS,
				`ISGOD_OP_CLP_CMP_DER_OFS,
				`ISGOD_OP_CLP_CMP_BIAS_OFS,
				`ISGOD_OP_CLP_CMP_HDER,
				`ISGOD_OP_CLP_OFS_HDER,
				`ISGOD_OP_CLP_CMP_OFS_HDER: op_kind = `ISGOD_K_SAMPLE; // RL1 RL2 RL10 RL11 RL12 RL13
				`ISGOD_OP_GTH,
				`ISGOD_OP_GTH_LOD,
				`ISGOD_OP_GTH_BIAS,
				`ISGOD_OP_GTH_LVL0,
				`ISGOD_OP_GTH_CMP,
				`ISGOD_OP_GTH_CMP_LVL0,
				`ISGOD_OP_GTH_OFS,
				`ISGOD_OP_GTH_LVL0_OFS,
				`ISGOD_OP_GTH_CMP_LVL0_OFS: op_kind = `ISGOD_K_GATHER; // RL3 RL5 RL6
				`ISGOD_OP_LOD_QUERY: op_kind = `ISGOD_K_LODQ; // RL8
				// holes and out-of-range opcodes are not texture ops
				default: op_kind = `ISGOD_K_NONE; // RL15
			endcase
		end
	endfunction

	// depth compare reference present
	function has_cmp;
		input [7:0] op;
		begin
			case (op)
				`ISGOD_OP_FILT_CMP_LOD_OFS,
				`ISGOD_OP_FILT_CMP_BIAS_OFS,
				`ISGOD_OP_FILT_CMP_LVL0_OFS,
				`ISGOD_OP_GTH_CMP,
				`ISGOD_OP_GTH_CMP_LVL0,
				`ISGOD_OP_GTH_CMP_LVL0_OFS,
				`ISGOD_OP_FILT_CMP_HDER,
				`ISGOD_OP_FILT_CMP_OFS_HDER,
				`ISGOD_OP_CLP_CMP,
				`ISGOD_OP_CLP_CMP_DER,
				`ISGOD_OP_CLP_CMP_BIAS,
				`ISGOD_OP_CLP_CMP_OFS,
				`ISGOD_OP_CLP_CMP_DER_OFS,
				`ISGOD_OP_CLP_CMP_BIAS_OFS,
				`ISGOD_OP_CLP_CMP_HDER,
				`ISGOD_OP_CLP_CMP_OFS_HDER: has_cmp = 1'h1;
				default: has_cmp = 1'h0;
			endcase
		end
	endfunction

	// explicit level of detail operand
	function has_lod;
		input [7:0] op;
		begin
			case (op)
				`ISGOD_OP_FILT_CMP_LOD_OFS,
				`ISGOD_OP_GTH_LOD: has_lod = 1'h1;
				default: has_lod = 1'h0;
			endcase
		end
	endfunction

	// lod bias operand
	function has_bias;
		input [7:0] op;
		begin
			case (op)
				`ISGOD_OP_FILT_CMP_BIAS_OFS,
				`ISGOD_OP_GTH_BIAS,
				`ISGOD_OP_CLP_BIAS,
				`ISGOD_OP_CLP_CMP_BIAS,
				`ISGOD_OP_CLP_BIAS_OFS,
				`ISGOD_OP_CLP_CMP_BIAS_OFS: has_bias = 1'h1;
				default: has_bias = 1'h0;
			endcase
		end
	endfunction

	// mip level pinned to zero, no lod computed or taken
	function has_lz;
		input [7:0] op;
		begin
			case (op)
				`ISGOD_OP_FILT_CMP_LVL0_OFS,
				`ISGOD_OP_GTH_LVL0,
				`ISGOD_OP_GTH_CMP_LVL0,
				`ISGOD_OP_GTH_LVL0_OFS,
				`ISGOD_OP_GTH_CMP_LVL0_OFS: has_lz = 1'h1;
				default: has_lz = 1'h0;
			endcase
		end
	endfunction

	// texel offsets operand
	function has_ofs;
		input [7:0] op;
		begin
			case (op)
				`ISGOD_OP_FILT_CMP_LOD_OFS,
				`ISGOD_OP_FILT_CMP_BIAS_OFS,
				`ISGOD_OP_FILT_CMP_LVL0_OFS,
				`ISGOD_OP_GTH_OFS,
				`ISGOD_OP_GTH_LVL0_OFS,
				`ISGOD_OP_GTH_CMP_LVL0_OFS,
				`ISGOD_OP_FILT_OFS_HDER,
				`ISGOD_OP_FILT_CMP_OFS_HDER,
				`ISGOD_OP_CLP_OFS,
				`ISGOD_OP_CLP_DER_OFS,
				`ISGOD_OP_CLP_BIAS_OFS,
				`ISGOD_OP_CLP_CMP_OFS,
				`ISGOD_OP_CLP_CMP_DER_OFS,
				`ISGOD_OP_CLP_CMP_BIAS_OFS,
				`ISGOD_OP_CLP_OFS_HDER,
				`ISGOD_OP_CLP_CMP_OFS_HDER: has_ofs = 1'h1;
				default: has_ofs = 1'h0;
			endcase
		end
	endfunction

	// lod clamp operand
	function has_clamp;
		input [7:0] op;
		begin
			case (op)
				`ISGOD_OP_CLP,
				`ISGOD_OP_CLP_DER,
				`ISGOD_OP_CLP_BIAS,
				`ISGOD_OP_CLP_CMP,
				`ISGOD_OP_CLP_CMP_DER,
				`ISGOD_OP_CLP_CMP_BIAS,
				`ISGOD_OP_CLP_OFS,
				`ISGOD_OP_CLP_DER_OFS,
				`ISGOD_OP_CLP_BIAS_OFS,
				`ISGOD_OP_CLP_CMP_OFS,
				`ISGOD_OP_CLP_CMP_DER_OFS,
				`ISGOD_OP_CLP_CMP_BIAS_OFS,
				`ISGOD_OP_CLP_CMP_HDER,
				`ISGOD_OP_CLP_OFS_HDER,
				`ISGOD_OP_CLP_CMP_OFS_HDER: has_clamp = 1'h1;
				default: has_clamp = 1'h0;
			endcase
		end
	endfunction

	// user derivatives operand, full or half width
	function has_der;
		input [7:0] op;
		begin
			case (op)
				`ISGOD_OP_FILT_HDER,
				`ISGOD_OP_FILT_CMP_HDER,
				`ISGOD_OP_FILT_OFS_HDER,
				`ISGOD_OP_FILT_CMP_OFS_HDER,
				`ISGOD_OP_CLP_DER,
				`ISGOD_OP_CLP_CMP_DER,
				`ISGOD_OP_CLP_DER_OFS,
				`ISGOD_OP_CLP_CMP_DER_OFS,
				`ISGOD_OP_CLP_CMP_HDER,
				`ISGOD_OP_CLP_OFS_HDER,
				`ISGOD_OP_CLP_CMP_OFS_HDER: has_der = 1'h1;
				default: has_der = 1'h0;
			endcase
		end
	endfunction

	// derivatives packed as 16-bit values
	function has_g16;
		input [7:0] op;
		begin
			case (op)
				`ISGOD_OP_FILT_HDER,
				`ISGOD_OP_FILT_CMP_HDER,
				`ISGOD_OP_FILT_OFS_HDER,
				`ISGOD_OP_FILT_CMP_OFS_HDER,
				`ISGOD_OP_CLP_CMP_HDER,
				`ISGOD_OP_CLP_OFS_HDER,
				`ISGOD_OP_CLP_CMP_OFS_HDER: has_g16 = 1'h1;
				default: has_g16 = 1'h0;
			endcase
		end
	endfunction

	// zero and multi-bit masks both count as wrong
	function is_one_hot;
		input [3:0] m;
		begin
			is_one_hot = (m != 4'h0) && ((m & (m - 4'h1)) == 4'h0);
		end
	endfunction

	reg [1:0] kind_nxt;
	reg [7:0] attr_nxt;
	reg valid_nxt;
	reg mem_nxt;
	reg [2:0] extra_nxt;
	reg illegal_nxt;
	reg mask_err_nxt;

	// all decode is combinational ahead of one flop stage: fixed 1-cycle latency
	always @* begin
		kind_nxt = op_kind(opcode_i);
		attr_nxt = 8'h00;
		attr_nxt[`ISGOD_A_CMP] = has_cmp(opcode_i); // RL2 RL5 RL10
		attr_nxt[`ISGOD_A_LOD] = has_lod(opcode_i); // RL2 RL3
		attr_nxt[`ISGOD_A_BIAS] = has_bias(opcode_i); // RL2 RL3 RL11
		attr_nxt[`ISGOD_A_LZ] = has_lz(opcode_i); // RL7
		attr_nxt[`ISGOD_A_OFS] = has_ofs(opcode_i); // RL6 RL12
		attr_nxt[`ISGOD_A_CLAMP] = has_clamp(opcode_i); // RL11 RL12 RL13
		attr_nxt[`ISGOD_A_DER] = has_der(opcode_i); // RL10 RL13
		attr_nxt[`ISGOD_A_G16] = has_g16(opcode_i); // RL10 RL13
		// an illegal opcode never issues an operation
		valid_nxt = issue_valid_i && (kind_nxt != `ISGOD_K_NONE); // RL15
		// fetch for sample and gather, none for lod query
		mem_nxt = issue_valid_i &&
			(kind_nxt == `ISGOD_K_SAMPLE || kind_nxt == `ISGOD_K_GATHER); // RL1 RL9
		// count of compare, bias and clamp operands beyond coordinates
		extra_nxt = {2'h0, attr_nxt[`ISGOD_A_CMP]} + {2'h0, attr_nxt[`ISGOD_A_BIAS]}
			+ {2'h0, attr_nxt[`ISGOD_A_CLAMP]}; // RL14
		illegal_nxt = issue_valid_i && (kind_nxt == `ISGOD_K_NONE); // RL15
		// issuer owns the one-hot mask; reported, not enforced
		mask_err_nxt = issue_valid_i && (kind_nxt == `ISGOD_K_GATHER) &&
			!is_one_hot(channel_select_mask_i); // RL4
	end

	// kind, attributes and mask follow the opcode even without valid;
	// consumers qualify them with op_valid_o
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			op_valid_o <= `ISGOD_RST_FLAG;
			op_kind_o <= `ISGOD_RST_KIND;
			op_attr_o <= `ISGOD_RST_ATTR;
			mem_access_o <= `ISGOD_RST_FLAG;
			channel_select_mask_o <= `ISGOD_RST_MASK;
			extra_operands_o <= `ISGOD_RST_EXTRA;
			illegal_o <= `ISGOD_RST_FLAG;
			mask_error_o <= `ISGOD_RST_FLAG;
		end else begin
			op_valid_o <= valid_nxt;
			op_kind_o <= kind_nxt;
			op_attr_o <= attr_nxt;
			mem_access_o <= mem_nxt;
			channel_select_mask_o <= channel_select_mask_i;
			extra_operands_o <= extra_nxt;
			illegal_o <= illegal_nxt;
			mask_error_o <= mask_err_nxt;
		end
	end
endmodule

// File: include/isgod_defines.vh
// Overview of operation
// [RL1] Every sampling opcode fetches texels at address-register coordinates and writes results.
// [RL2] Opcodes 44, 45, 46 are compare sampling with offsets plus LOD, bias and level zero.
// [RL3] Opcodes 47 to 50 are four-texel fetches: plain, explicit LOD, bias and level zero.
// [RL4] The issuer sets exactly one bit of the channel select mask for every gather opcode.
// [RL5] Opcode 51 is compare gather, 52 compare gather at level zero, 53 gather with offsets.
// [RL6] Opcode 54 is offset gather at level zero and 55 is compare offset gather at level zero.
// [RL7] Every level-zero variant forces the mip level to zero.
// [RL8] Opcode 56 returns the clamped LOD in the first dword and the raw LOD in the second.
// [RL9] The LOD query performs no memory access and only writes the LOD values.
// [RL10] Opcodes 57 to 60 are half-derivative sampling: plain, compare, offset, compare+offset.
// [RL11] Opcodes 64 to 69 are clamped sampling: plain, deriv, bias, cmp, cmp+deriv, cmp+bias.
// [RL12] Opcodes 70 to 75 are clamped offset sampling; 73 to 75 are compare forms of 70 to 72.
// [RL13] Opcodes 84 to 86 are clamped half-derivative sampling: cmp, offset, cmp+offset.
// [RL14] Compare opcodes with bias and clamp read reference, bias and clamp operands too.
// [RL15] Unassigned opcodes in the range, 61 to 63 and 76 to 83, are flagged illegal.
`ifndef ISGOD_DEFINES_VH
`define ISGOD_DEFINES_VH
`define ISGOD_OP_W 8
`define ISGOD_OP_FIRST 8'h2C
`define ISGOD_OP_LAST 8'h56
`define ISGOD_OP_LOD_QUERY 8'h38
// legal opcodes, named by what they add to the basic fetch
`define ISGOD_OP_FILT_CMP_LOD_OFS 8'h2C
`define ISGOD_OP_FILT_CMP_BIAS_OFS 8'h2D
`define ISGOD_OP_FILT_CMP_LVL0_OFS 8'h2E
`define ISGOD_OP_GTH 8'h2F
`define ISGOD_OP_GTH_LOD 8'h30
`define ISGOD_OP_GTH_BIAS 8'h31
`define ISGOD_OP_GTH_LVL0 8'h32
`define ISGOD_OP_GTH_CMP 8'h33
`define ISGOD_OP_GTH_CMP_LVL0 8'h34
`define ISGOD_OP_GTH_OFS 8'h35
`define ISGOD_OP_GTH_LVL0_OFS 8'h36
`define ISGOD_OP_GTH_CMP_LVL0_OFS 8'h37
`define ISGOD_OP_FILT_HDER 8'h39
`define ISGOD_OP_FILT_CMP_HDER 8'h3A
`define ISGOD_OP_FILT_OFS_HDER 8'h3B
`define ISGOD_OP_FILT_CMP_OFS_HDER 8'h3C
`define ISGOD_OP_CLP 8'h40
`define ISGOD_OP_CLP_DER 8'h41
`define ISGOD_OP_CLP_BIAS 8'h42
`define ISGOD_OP_CLP_CMP 8'h43
`define ISGOD_OP_CLP_CMP_DER 8'h44
`define ISGOD_OP_CLP_CMP_BIAS 8'h45
`define ISGOD_OP_CLP_OFS 8'h46
`define ISGOD_OP_CLP_DER_OFS 8'h47
`define ISGOD_OP_CLP_BIAS_OFS 8'h48
`define ISGOD_OP_CLP_CMP_OFS 8'h49
`define ISGOD_OP_CLP_CMP_DER_OFS 8'h4A
`define ISGOD_OP_CLP_CMP_BIAS_OFS 8'h4B
`define ISGOD_OP_CLP_CMP_HDER 8'h54
`define ISGOD_OP_CLP_OFS_HDER 8'h55
`define ISGOD_OP_CLP_CMP_OFS_HDER 8'h56
// attribute vector bit positions
`define ISGOD_A_CMP 0
`define ISGOD_A_LOD 1
`define ISGOD_A_BIAS 2
`define ISGOD_A_LZ 3
`define ISGOD_A_OFS 4
`define ISGOD_A_CLAMP 5
`define ISGOD_A_DER 6
`define ISGOD_A_G16 7
`define ISGOD_A_W 8
// operation kind codes
`define ISGOD_K_SAMPLE 2'h0
`define ISGOD_K_GATHER 2'h1
`define ISGOD_K_LODQ 2'h2
`define ISGOD_K_NONE 2'h3
// reset values of the output flops
`define ISGOD_RST_FLAG 1'h0
`define ISGOD_RST_KIND `ISGOD_K_NONE
`define ISGOD_RST_ATTR 8'h00
`define ISGOD_RST_MASK 4'h0
`define ISGOD_RST_EXTRA 3'h0
`endif
